// file: shared/psram_host_map.svh
`ifndef PSRAM_HOST_MAP_SVH
`define PSRAM_HOST_MAP_SVH

// array shape: 256K locations of one byte
`define PSRAM_ADDR_W 18
`define PSRAM_DATA_W 8
`define PSRAM_DEPTH 262144

// clock and pin timing
`define CLK_PERIOD_NS 8
`define T_RC_NS 70
`define T_ACE_NS 70
`define T_WC_NS 70
`define T_SCE_NS 55
`define T_PWE_NS 55
`define T_SD_NS 25

// least times round up to whole cycles
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RC_CYC `NS_TO_CYC(`T_RC_NS)
`define T_ACE_CYC `NS_TO_CYC(`T_ACE_NS)
`define T_WC_CYC `NS_TO_CYC(`T_WC_NS)
`define T_WR_CYC `NS_TO_CYC(`T_PWE_NS)

`define TIMER_W 8

`endif

// file: shared/psram_host_pkg.sv
`include "psram_host_map.svh"

package psram_host_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_RD_ACT = 3'b010,
        ST_WR_ACT = 3'b011,
        ST_WR_END = 3'b100,
        ST_RECOVER = 3'b101
    } host_state_type;

    typedef struct packed {
        host_state_type state;
        logic is_write;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
        logic [`PSRAM_ADDR_W-1:0] addr;
        logic [`PSRAM_DATA_W-1:0] dq_o;
        logic [`PSRAM_DATA_W-1:0] rdata;
        logic rvalid;
        logic wdone;
    } host_regs_type;

    typedef struct packed {
        logic [`TIMER_W-1:0] cnt;
    } timer_regs_type;

endpackage

// file: shared/cycle_timer_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "psram_host_map.svh"

interface cycle_timer_if;
    logic load;
    logic [`TIMER_W-1:0] value;
    logic done;

    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface

`default_nettype wire

// file: hw/cycle_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "psram_host_map.svh"

// done is high in the Nth cycle after a load of N (N at least one)
module cycle_timer
    import psram_host_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    cycle_timer_if.tmr tif
);

    timer_regs_type r_q;
    timer_regs_type r_d;

    always_comb begin
        r_d = r_q;
        if (tif.load) begin
            r_d.cnt = tif.value;
        end else if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - `TIMER_W'(1);
        end
    end

    assign tif.done = (r_q.cnt == `TIMER_W'(1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

endmodule // cycle_timer

`default_nettype wire

// file: hw/psram_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "psram_host_map.svh"

// Notes on behaviour
// - write spans only the overlap of select and write strobe
// - host holds write data across whichever edge ends the write
// - host starts reads with select, address stable before select falls
// - slower grade needs address settled 10 ns into the read cycle
// - long runs of short address changes need full reads or long deselect
// - host never drives data while device may drive with output enable low
module psram_host
    import psram_host_pkg::*;
#(
    parameter int RD_ACCESS_CYC = `T_ACE_CYC,
    parameter int RD_CYCLE_CYC = `T_RC_CYC,
    parameter int WR_PULSE_CYC = `T_WR_CYC,
    parameter int WR_CYCLE_CYC = `T_WC_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic req_write,
    input wire logic [`PSRAM_ADDR_W-1:0] req_addr,
    input wire logic [`PSRAM_DATA_W-1:0] req_wdata,
    output logic ready,
    output logic [`PSRAM_DATA_W-1:0] rdata,
    output logic rvalid,
    output logic wdone,
    output logic mem_ce_n,
    output logic mem_oe_n,
    output logic mem_we_n,
    output logic [`PSRAM_ADDR_W-1:0] mem_addr,
    output logic [`PSRAM_DATA_W-1:0] mem_dq_o,
    output logic mem_dq_oe_n,
    input wire logic [`PSRAM_DATA_W-1:0] mem_dq_i
);

    // cycles left after the active phase and the write hold cycle; setup cycles add margin
    localparam int RD_REST = RD_CYCLE_CYC - RD_ACCESS_CYC;
    localparam int WR_REST = WR_CYCLE_CYC - WR_PULSE_CYC - 1;
    localparam int RD_REC = (RD_REST < 1) ? 1 : RD_REST;
    localparam int WR_REC = (WR_REST < 1) ? 1 : WR_REST;

    // largest count the timer can hold
    localparam int TMR_MAX = (1 << `TIMER_W) - 1;

    // loads stay inside the timer and never reach zero, so no phase hangs
    function automatic logic [`TIMER_W-1:0] fit_count(input int n);
        logic [`TIMER_W-1:0] v;
        if (n < 1) begin
            v = `TIMER_W'(1);
        end else if (n > TMR_MAX) begin
            v = `TIMER_W'(TMR_MAX);
        end else begin
            v = `TIMER_W'(n);
        end
        return v;
    endfunction

    // timer load for each phase
    localparam logic [`TIMER_W-1:0] RD_ACT_LD = fit_count(RD_ACCESS_CYC);
    localparam logic [`TIMER_W-1:0] WR_ACT_LD = fit_count(WR_PULSE_CYC);
    localparam logic [`TIMER_W-1:0] RD_REC_LD = fit_count(RD_REC);
    localparam logic [`TIMER_W-1:0] WR_REC_LD = fit_count(WR_REC);

    host_regs_type r_q;
    host_regs_type r_d;
    cycle_timer_if tif ();

    cycle_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .tif(tif)
    );

    always_comb begin
        r_d = r_q;
        r_d.rvalid = 1'b0;
        r_d.wdone = 1'b0;
        tif.load = 1'b0;
        tif.value = '0;
        ready = 1'b0;
        case (r_q.state)
            ST_IDLE: begin
                ready = 1'b1;
                if (req) begin
                    // address set while still deselected
                    r_d.addr = req_addr;
                    r_d.is_write = req_write;
                    if (req_write) begin
                        // driven from the start for a long setup to the end
                        r_d.dq_o = req_wdata;
                        r_d.dq_oe_n = 1'b0;
                    end
                    r_d.state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                r_d.ce_n = 1'b0;
                if (r_q.is_write) begin
                    // output enable stays high in writes
                    r_d.we_n = 1'b0;
                    tif.value = WR_ACT_LD;
                    r_d.state = ST_WR_ACT;
                end else begin
                    // select and output enable fall together, address stable
                    r_d.oe_n = 1'b0;
                    tif.value = RD_ACT_LD;
                    r_d.state = ST_RD_ACT;
                end
                tif.load = 1'b1;
            end
            ST_RD_ACT: begin
                if (tif.done) begin
                    // sampled in the last access cycle, data settled by then
                    r_d.rdata = mem_dq_i;
                    r_d.rvalid = 1'b1;
                    r_d.ce_n = 1'b1;
                    r_d.oe_n = 1'b1;
                    tif.load = 1'b1;
                    tif.value = RD_REC_LD;
                    r_d.state = ST_RECOVER;
                end
            end
            ST_WR_ACT: begin
                if (tif.done) begin
                    // both strobes end the write together
                    r_d.we_n = 1'b1;
                    r_d.ce_n = 1'b1;
                    r_d.state = ST_WR_END;
                end
            end
            ST_WR_END: begin
                // data held one cycle past the ending edge
                r_d.dq_oe_n = 1'b1;
                r_d.wdone = 1'b1;
                tif.load = 1'b1;
                tif.value = WR_REC_LD;
                r_d.state = ST_RECOVER;
            end
            ST_RECOVER: begin
                // deselected cycles make up the rest of the cycle time
                if (tif.done) begin
                    r_d.state = ST_IDLE;
                end
            end
            default: begin
                r_d.state = ST_IDLE;
                r_d.ce_n = 1'b1;
                r_d.oe_n = 1'b1;
                r_d.we_n = 1'b1;
                r_d.dq_oe_n = 1'b1;
                r_d.is_write = 1'b0;
            end
        endcase
        // interlocks on the next pin state, whatever the branch chose
        if (r_d.ce_n) begin
            // a strobe without select starts nothing; drop both with it
            r_d.we_n = 1'b1;
            r_d.oe_n = 1'b1;
        end
        if (!r_d.we_n) begin
            // output enable stays high across the whole write
            r_d.oe_n = 1'b1;
        end
        if (!r_d.oe_n) begin
            // device may drive the pins, so the host driver stays off
            r_d.dq_oe_n = 1'b1;
        end
        if (!r_q.ce_n) begin
            // address frozen for the whole selected phase
            r_d.addr = r_q.addr;
        end
        if (!r_q.we_n) begin
            // write data frozen while the strobe is low
            r_d.dq_o = r_q.dq_o;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_q.state <= ST_IDLE;
            r_q.is_write <= 1'b0;
            r_q.ce_n <= 1'b1;
            r_q.oe_n <= 1'b1;
            r_q.we_n <= 1'b1;
            r_q.dq_oe_n <= 1'b1;
            r_q.addr <= '0;
            r_q.dq_o <= '0;
            r_q.rdata <= '0;
            r_q.rvalid <= 1'b0;
            r_q.wdone <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // user side
    assign rdata = r_q.rdata;
    assign rvalid = r_q.rvalid;
    assign wdone = r_q.wdone;

    // memory pins, all straight from flip-flops
    assign mem_ce_n = r_q.ce_n;
    assign mem_oe_n = r_q.oe_n;
    assign mem_we_n = r_q.we_n;
    assign mem_addr = r_q.addr;
    assign mem_dq_o = r_q.dq_o;
    assign mem_dq_oe_n = r_q.dq_oe_n;

endmodule // psram_host

`default_nettype wire

// file: verification/psram_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "psram_host_map.svh"
module psram_host_sva #(
    parameter int RD_ACCESS_CYC = 9,
    parameter int WR_PULSE_CYC = 7
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic mem_ce_n,
    input wire logic mem_oe_n,
    input wire logic mem_we_n,
    input wire logic [`PSRAM_ADDR_W-1:0] mem_addr,
    input wire logic [`PSRAM_DATA_W-1:0] mem_dq_o,
    input wire logic mem_dq_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] low_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) low_q <= 8'h00;
        else low_q <= mem_ce_n ? 8'h00 : low_q + 8'h01;
    end
    sequence deselect_gap;
        mem_ce_n [*3];
    endsequence
    no_contend_a: assert property (!mem_oe_n |-> mem_dq_oe_n)
        else $error("host drives data under output enable");
    wr_hold_a: assert property ($rose(mem_we_n) |->
        !mem_dq_oe_n && $stable(mem_dq_o)) else $error("write data not held");
    addr_setup_a: assert property ($fell(mem_ce_n) && mem_we_n |->
        $fell(mem_oe_n) && $stable(mem_addr)) else $error("read not ce led");
    addr_steady_a: assert property (!mem_ce_n |-> $stable(mem_addr))
        else $error("address moved while selected");
    sel_gap_a: assert property ($rose(mem_ce_n) |-> deselect_gap)
        else $error("deselect too short");
    pulse_len_a: assert property ($rose(mem_ce_n) |-> low_q ==
        8'($past(mem_we_n) ? RD_ACCESS_CYC : WR_PULSE_CYC))
        else $error("select low time wrong");
    wr_overlap_a: assert property (!mem_we_n |->
        !mem_ce_n && mem_oe_n && !mem_dq_oe_n) else $error("bad write pins");
endmodule // psram_host_sva
bind psram_host psram_host_sva #(
    .RD_ACCESS_CYC(RD_ACCESS_CYC),
    .WR_PULSE_CYC(WR_PULSE_CYC)
) sva_u (.clk(clk), .rstn(rstn), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o),
    .mem_dq_oe_n(mem_dq_oe_n));
`default_nettype wire

// file: verification/psram_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "psram_host_map.svh"
module psram_dev_model (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [`PSRAM_ADDR_W-1:0] addr,
    input wire logic [`PSRAM_DATA_W-1:0] din,
    output logic [`PSRAM_DATA_W-1:0] dout
);
    logic [7:0] mem [`PSRAM_DEPTH];
    logic [7:0] last = 8'h00;
    wire drv = !ce_n && !oe_n && we_n;
    wire wr = !ce_n && !we_n;
    always @(negedge wr) mem[addr] = din;
    always @* if (drv) last = mem[addr];
    // released bus shows the inverse, never a stale copy
    assign dout = drv ? mem[addr] : ~last;
endmodule // psram_dev_model
`default_nettype wire

// file: verification/tb_psram_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "psram_host_map.svh"
module tb_psram_host;
    logic clk, rstn, req, req_write, ready, rvalid, wdone;
    logic ce_n, oe_n, we_n, dq_oe_n;
    logic [`PSRAM_ADDR_W-1:0] req_addr, mem_addr;
    logic [`PSRAM_DATA_W-1:0] req_wdata, rdata, dq_o, dq_i, dout, r;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    psram_host dut (.clk(clk), .rstn(rstn), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready),
        .rdata(rdata), .rvalid(rvalid), .wdone(wdone), .mem_ce_n(ce_n),
        .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_addr(mem_addr),
        .mem_dq_o(dq_o), .mem_dq_oe_n(dq_oe_n), .mem_dq_i(dq_i));
    psram_dev_model dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(mem_addr), .din(dq_i), .dout(dout));
    assign dq_i = dq_oe_n ? dout : dq_o;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [17:0] a,
                       input logic [7:0] d, input int lat);
        int n;
        n = 0;
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (rvalid !== 1'b1 && wdone !== 1'b1 && n < 40);
        chk(n, lat);
        r = rdata;
    endtask
    task automatic t_edges;
        acc(1'b1, 18'h00000, 8'h3c, `T_WR_CYC + 3);
        acc(1'b1, 18'h3ffff, 8'hc3, `T_WR_CYC + 3);
        acc(1'b0, 18'h00000, 8'h00, `T_ACE_CYC + 2);
        chk(r, 8'h3c);
        acc(1'b0, 18'h3ffff, 8'h00, `T_ACE_CYC + 2);
        chk(r, 8'hc3);
    endtask
    // a write request raised mid-read must be ignored
    task automatic t_refuse;
        acc(1'b1, 18'h15a5a, 8'h5a, `T_WR_CYC + 3);
        fork
            acc(1'b0, 18'h15a5a, 8'h00, `T_ACE_CYC + 2);
            begin
                do @(negedge clk); while (oe_n !== 1'b0);
                @(posedge clk);
                req <= 1'b1;
                req_write <= 1'b1;
                req_wdata <= 8'ha5;
                repeat (3) @(posedge clk);
                req <= 1'b0;
            end
        join
        chk(r, 8'h5a);
        acc(1'b0, 18'h15a5a, 8'h00, `T_ACE_CYC + 2);
        chk(r, 8'h5a);
    endtask
    // reset in the middle of a write returns every pin to idle
    task automatic t_reset;
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        req <= 1'b1;
        req_write <= 1'b1;
        req_addr <= 18'h2aaaa;
        req_wdata <= 8'h99;
        @(posedge clk);
        req <= 1'b0;
        do @(negedge clk); while (we_n !== 1'b0);
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk({ready, ce_n, oe_n, we_n, dq_oe_n}, 32'h1f);
        chk({mem_addr, dq_o}, 32'h0);
        chk({rdata, rvalid, wdone}, 32'h0);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        acc(1'b0, 18'h3ffff, 8'h00, `T_ACE_CYC + 2);
        chk(r, 8'hc3);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 600) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 18'h00000;
        req_wdata = 8'h00;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_edges();
        t_refuse();
        t_reset();
        results();
    end
endmodule // tb_psram_host
`default_nettype wire
